/* common/ecmc_pkg.sv */
package ecmc_pkg;
  // Register index on the plain bus
  localparam logic [3:0] OFS_TCNT = 4'h0;
  localparam logic [3:0] OFS_PERIOD = 4'h1;
  localparam logic [3:0] OFS_TCTRL = 4'h2;
  localparam logic [3:0] OFS_U1_LO = 4'h3;
  localparam logic [3:0] OFS_U1_HI = 4'h4;
  localparam logic [3:0] OFS_U1_CTRL = 4'h5;
  localparam logic [3:0] OFS_U2_LO = 4'h6;
  localparam logic [3:0] OFS_U2_HI = 4'h7;
  localparam logic [3:0] OFS_U2_CTRL = 4'h8;
  localparam logic [3:0] OFS_SHDN = 4'h9;
  localparam logic [3:0] OFS_DBCFG = 4'ha;
  localparam logic [3:0] OFS_STATUS = 4'hb;
  // Field positions
  localparam int CFG_LSB = 6;
  localparam int DUTY_LSB = 4;
  localparam int TCTRL_ON_BIT = 2;
  localparam int STAT_FLAG_BIT = 0;
  // Reset values and read masks
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] U2_CTRL_MASK = 8'h3f;
  localparam logic [7:0] TCTRL_MASK = 8'h7f;
  localparam logic [7:0] SHDN_SMALL_MASK = 8'hfc;
  localparam logic [7:0] DBCFG_SMALL_MASK = 8'h80;
  // Capture dividers, stored as terminal count
  localparam logic [3:0] CAP_DIV4_END = 4'h3;
  localparam logic [3:0] CAP_DIV16_END = 4'hf;
  // Mode select codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_RSVD = 4'h1;
  localparam logic [3:0] MODE_CMP_TOG = 4'h2;
  localparam logic [3:0] MODE_CAP_ANY = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_R4 = 4'h6;
  localparam logic [3:0] MODE_CAP_R16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SW = 4'ha;
  localparam logic [3:0] MODE_CMP_SPEC = 4'hb;

  typedef enum logic [1:0] {
    CFG_SINGLE = 2'b00,
    CFG_FWD = 2'b01,
    CFG_HALF = 2'b10,
    CFG_REV = 2'b11
  } ecmc_cfg_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ecmc_bus_s;
endpackage : ecmc_pkg

/* src/ecmc_top.sv */
// Functional notes
// - Shutdown logic belongs to first unit only
// - Compare modes 0010, 1000, 1001 and capture modes: A owned, B-D port pins
// - Single config: only A modulated
// - Forward: D modulated, A active, B/C inactive
// - Half-bridge: A and B modulated, C/D port
// - Reverse: B modulated, C active, A/D inactive
// - Control bits 5:4 are duty LSBs
// - Mode 0000 off and resets state
// - Mode 0010 toggles pin on match
// - Modes 0011-0111 select capture edges
// - Mode 1000 init low, set on match
// - Mode 1001 init high, clear on match
// - Mode 1010 flag only, pin released
// - Mode 1011 resets selected timer, flags
// - PWM polarity from mode bits 1 and 0
// - Small package bits read zero
// - Unimplemented bits read zero
// - Control register read/write, resets zero
// - Period end clears timer, loads duty
`timescale 1ns/1ps
module ecmc_top #(
  parameter bit SMALL_PKG = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire ecmc_pkg::ecmc_bus_s bus_i,
  input wire logic [15:0] ext_timer_i,
  input wire logic cap_in_i,
  input wire logic [3:0] port_latch_i,
  input wire logic [3:0] port_dir_i,
  output logic [7:0] rdata_o,
  output logic [3:0] pin_o,
  output logic [3:0] pin_oe_o,
  output logic timer_reset_o,
  output logic event_flag_o
);
  import ecmc_pkg::*;

  logic [7:0] tcnt_q;
  logic [7:0] period_q;
  logic [7:0] tctrl_q;
  logic [7:0] u1_lo_q;
  logic [7:0] u1_hi_q;
  logic [7:0] ctrl_q;
  logic [7:0] u2_lo_q;
  logic [7:0] u2_hi_q;
  logic [7:0] u2_ctrl_q;
  logic [7:0] shdn_q;
  logic [7:0] dbcfg_q;
  logic flag_q;
  logic [5:0] fine_q;
  logic pwm_q;
  logic [1:0] dl_q;
  logic cmp_pin_q;
  logic match_prev_q;
  logic cap_prev_q;
  logic [3:0] capdiv_q;
  logic [3:0] mode_prev_q;
  logic [3:0] own;
  logic [3:0] act;
  logic [3:0] pol;

  logic wr;
  logic rd;
  logic [3:0] mode;
  ecmc_cfg_e cfg;
  logic pwm_mode;
  logic is_cap;
  logic is_cmp;
  logic t_on;
  logic tick_end;
  logic [1:0] fine2;
  logic period_end;
  logic duty_hit;
  logic cmp_hit;
  logic cap_rise;
  logic cap_fall;
  logic cap_hit;

  assign wr = bus_i.wr;
  assign rd = bus_i.rd;
  assign mode = ctrl_q[3:0];
  assign cfg = ecmc_cfg_e'(ctrl_q[CFG_LSB+:2]);
  assign pwm_mode = (mode[3:2] == 2'b11);
  assign is_cap = (mode >= MODE_CAP_ANY) && (mode <= MODE_CAP_R16);
  assign is_cmp = (mode == MODE_CMP_TOG) || (mode[3:2] == 2'b10);
  assign t_on = tctrl_q[TCTRL_ON_BIT];
  assign event_flag_o = flag_q;

  // Prescale 1, 4 or 16 on top of a 4-clock base step
  always_comb begin
    unique case (tctrl_q[1:0])
      2'b00: begin
        tick_end = (fine_q[1:0] == 2'h3);
        fine2 = fine_q[1:0];
      end
      2'b01: begin
        tick_end = (fine_q[3:0] == 4'hf);
        fine2 = fine_q[3:2];
      end
      default: begin
        tick_end = (fine_q == 6'h3f);
        fine2 = fine_q[5:4];
      end
    endcase
  end

  assign period_end = t_on && tick_end && (tcnt_q == period_q);
  assign duty_hit = t_on && ({tcnt_q, fine2} == {u1_hi_q, dl_q});
  assign cmp_hit = is_cmp && (ext_timer_i == {u1_hi_q, u1_lo_q}) && !match_prev_q;
  assign cap_rise = cap_in_i && !cap_prev_q;
  assign cap_fall = !cap_in_i && cap_prev_q;

  always_comb begin
    unique case (mode)
      MODE_CAP_ANY: cap_hit = cap_rise || cap_fall;
      MODE_CAP_FALL: cap_hit = cap_fall;
      MODE_CAP_RISE: cap_hit = cap_rise;
      MODE_CAP_R4: cap_hit = cap_rise && (capdiv_q == CAP_DIV4_END);
      MODE_CAP_R16: cap_hit = cap_rise && (capdiv_q == CAP_DIV16_END);
      default: cap_hit = 1'b0;
    endcase
  end

  // Period timer; software writes land on the count directly
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tcnt_q <= RST_REG;
      fine_q <= '0;
    end else begin
      fine_q <= t_on ? (tick_end ? 6'h00 : fine_q + 6'h01) : 6'h00;
      if (wr && bus_i.addr == OFS_TCNT) begin
        tcnt_q <= bus_i.wdata;
      end else if (period_end) begin
        tcnt_q <= RST_REG;
      end else if (t_on && tick_end) begin
        tcnt_q <= tcnt_q + 8'h01;
      end
    end
  end

  // Plain software registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      period_q <= RST_REG;
      tctrl_q <= RST_REG;
      u1_lo_q <= RST_REG;
      ctrl_q <= RST_REG;
      u2_lo_q <= RST_REG;
      u2_hi_q <= RST_REG;
      u2_ctrl_q <= RST_REG;
      shdn_q <= RST_REG;
      dbcfg_q <= RST_REG;
    end else if (wr) begin
      unique case (bus_i.addr)
        OFS_PERIOD: period_q <= bus_i.wdata;
        OFS_TCTRL: tctrl_q <= bus_i.wdata & TCTRL_MASK;
        OFS_U1_LO: u1_lo_q <= bus_i.wdata;
        OFS_U1_CTRL: ctrl_q <= bus_i.wdata;
        OFS_U2_LO: u2_lo_q <= bus_i.wdata;
        OFS_U2_HI: u2_hi_q <= bus_i.wdata;
        OFS_U2_CTRL: u2_ctrl_q <= bus_i.wdata & U2_CTRL_MASK;
        // Shutdown control exists for the first unit alone
        OFS_SHDN: shdn_q <= bus_i.wdata & (SMALL_PKG ? SHDN_SMALL_MASK : 8'hff);
        OFS_DBCFG: dbcfg_q <= bus_i.wdata & (SMALL_PKG ? DBCFG_SMALL_MASK : 8'hff);
        default: ;
      endcase
    end
  end

  // High byte: capture target, duty buffer in PWM, read-only there
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      u1_hi_q <= RST_REG;
    end else if (pwm_mode) begin
      if (period_end) begin
        u1_hi_q <= u1_lo_q;
      end
    end else if (cap_hit) begin
      u1_hi_q <= ext_timer_i[15:8];
    end else if (wr && bus_i.addr == OFS_U1_HI) begin
      u1_hi_q <= bus_i.wdata;
    end
  end

  // Two-bit duty latch, cleared while the unit is off
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || mode == MODE_OFF) begin
      dl_q <= 2'b00;
    end else if (pwm_mode && period_end) begin
      dl_q <= ctrl_q[DUTY_LSB+:2];
    end
  end

  // Captured low byte is kept until software overwrites it or the unit stops
  logic [7:0] cap_lo_q;
  logic cap_lo_vld_q;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cap_prev_q <= 1'b0;
      cap_lo_q <= RST_REG;
      cap_lo_vld_q <= 1'b0;
    end else begin
      // Pin history runs in every mode, so entering capture sees no false edge
      cap_prev_q <= cap_in_i;
      if (cap_hit) begin
        cap_lo_q <= ext_timer_i[7:0];
        cap_lo_vld_q <= 1'b1;
      end else if (mode == MODE_OFF || (wr && bus_i.addr == OFS_U1_LO)) begin
        cap_lo_vld_q <= 1'b0;
      end
    end
  end

  // Match history and capture prescale
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || mode == MODE_OFF) begin
      match_prev_q <= 1'b0;
      capdiv_q <= 4'h0;
    end else begin
      match_prev_q <= (ext_timer_i == {u1_hi_q, u1_lo_q});
      if (mode != mode_prev_q) begin
        capdiv_q <= 4'h0;
      end else if (cap_hit) begin
        capdiv_q <= 4'h0;
      end else if (cap_rise) begin
        capdiv_q <= capdiv_q + 4'h1;
      end
    end
  end

  // Compare pin state; entering a mode sets its start level
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cmp_pin_q <= 1'b0;
      mode_prev_q <= MODE_OFF;
    end else begin
      mode_prev_q <= mode;
      if (mode != mode_prev_q) begin
        cmp_pin_q <= (mode == MODE_CMP_CLR);
      end else if (cmp_hit) begin
        unique case (mode)
          MODE_CMP_TOG: cmp_pin_q <= !cmp_pin_q;
          MODE_CMP_SET: cmp_pin_q <= 1'b1;
          MODE_CMP_CLR: cmp_pin_q <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  // Event flag: hardware set wins over a write-one clear
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      flag_q <= 1'b0;
    end else if (cmp_hit || cap_hit) begin
      flag_q <= 1'b1;
    end else if (wr && bus_i.addr == OFS_STATUS && bus_i.wdata[STAT_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      timer_reset_o <= 1'b0;
    end else begin
      timer_reset_o <= cmp_hit && (mode == MODE_CMP_SPEC);
    end
  end

  // Modulator: set at period end unless duty is zero
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !pwm_mode) begin
      pwm_q <= 1'b0;
    end else if (period_end) begin
      pwm_q <= ({u1_lo_q, ctrl_q[DUTY_LSB+:2]} != 10'h000);
    end else if (duty_hit) begin
      pwm_q <= 1'b0;
    end
  end

  // Pin ownership and raw active levels
  always_comb begin
    own = 4'b0000;
    act = 4'b0000;
    if (pwm_mode) begin
      unique case (cfg)
        CFG_SINGLE: begin
          own = 4'b0001;
          act = {3'b000, pwm_q};
        end
        CFG_FWD: begin
          own = 4'b1111;
          act = {pwm_q, 1'b0, 1'b0, 1'b1};
        end
        CFG_HALF: begin
          own = 4'b0011;
          act = {2'b00, !pwm_q, pwm_q};
        end
        CFG_REV: begin
          own = 4'b1111;
          act = {1'b0, 1'b1, pwm_q, 1'b0};
        end
      endcase
    end else if (mode == MODE_CMP_TOG || mode == MODE_CMP_SET || mode == MODE_CMP_CLR) begin
      own = 4'b0001;
      act = {3'b000, cmp_pin_q};
    end else if (is_cap) begin
      own = 4'b0001;
    end
  end

  // A and C share one polarity bit, B and D the other
  assign pol = pwm_mode ? {mode[0], mode[1], mode[0], mode[1]} : 4'b0000;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          pin_o[gi] <= 1'b0;
          pin_oe_o[gi] <= 1'b0;
        end else begin
          pin_o[gi] <= own[gi] ? (act[gi] ^ pol[gi]) : port_latch_i[gi];
          // Direction stays with the port in every mode
          pin_oe_o[gi] <= !port_dir_i[gi];
        end
      end
    end
  endgenerate

  // Read data one cycle after the strobe; unmapped reads give zero
  logic [7:0] u1_lo_rd;
  assign u1_lo_rd = cap_lo_vld_q ? cap_lo_q : u1_lo_q;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o <= RST_REG;
    end else if (rd) begin
      unique case (bus_i.addr)
        OFS_TCNT: rdata_o <= tcnt_q;
        OFS_PERIOD: rdata_o <= period_q;
        OFS_TCTRL: rdata_o <= tctrl_q;
        OFS_U1_LO: rdata_o <= u1_lo_rd;
        OFS_U1_HI: rdata_o <= u1_hi_q;
        OFS_U1_CTRL: rdata_o <= ctrl_q;
        OFS_U2_LO: rdata_o <= u2_lo_q;
        OFS_U2_HI: rdata_o <= u2_hi_q;
        OFS_U2_CTRL: rdata_o <= u2_ctrl_q;
        OFS_SHDN: rdata_o <= shdn_q;
        OFS_DBCFG: rdata_o <= dbcfg_q;
        OFS_STATUS: rdata_o <= {7'h00, flag_q};
        default: rdata_o <= RST_REG;
      endcase
    end else begin
      rdata_o <= RST_REG;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  off_release_a: assert property (
    (mode == MODE_OFF) |=> (pin_o == $past(port_latch_i)))
    else $error("off mode pins not released");
  cap_pins_a: assert property (
    is_cap |=> (pin_o[3:1] == $past(port_latch_i[3:1])))
    else $error("capture mode drove B-D");
  fwd_map_a: assert property (
    (pwm_mode && cfg == CFG_FWD) |=> (pin_o[0] == !$past(mode[1]) && pin_o[1] == $past(mode[0])))
    else $error("forward bridge levels wrong");
  rev_map_a: assert property (
    (pwm_mode && cfg == CFG_REV) |=> (pin_o[2] == !$past(mode[1]) && pin_o[3] == $past(mode[0])))
    else $error("reverse bridge levels wrong");
  duty_load_a: assert property (
    (pwm_mode && period_end) |=> (u1_hi_q == $past(u1_lo_q) && dl_q == $past(ctrl_q[5:4])))
    else $error("duty not loaded at period end");
  match_flag_a: assert property (
    cmp_hit |=> flag_q)
    else $error("flag not set on compare match");
  spec_reset_a: assert property (
    (cmp_hit && mode == MODE_CMP_SPEC) |=> timer_reset_o ##1 !timer_reset_o)
    else $error("special event pulse wrong");
  clr_init_a: assert property (
    (mode == MODE_CMP_CLR && mode_prev_q != MODE_CMP_CLR) |=> cmp_pin_q)
    else $error("clear mode did not start high");
  sw_release_a: assert property (
    (mode == MODE_CMP_SW) |=> (pin_o[0] == $past(port_latch_i[0])))
    else $error("software-only compare drove pin A");
  u2_read_a: assert property (
    (rd && bus_i.addr == OFS_U2_CTRL) |=> (rdata_o[7:6] == 2'b00))
    else $error("unimplemented bits read nonzero");
endmodule : ecmc_top

/* sim/ecmc_bridge_model.sv */
`timescale 1ns/1ps
module ecmc_bridge_model (
  input wire logic [3:0] pin_i,
  input wire logic [3:0] oe_i,
  input wire logic drive_a_i,
  output logic [3:0] pad_o,
  output logic cap_o
);
  // Gate inputs of the bridge carry pull-downs, so a pin nobody drives reads low
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      pad_o[k] = oe_i[k] ? pin_i[k] : 1'b0;
    end
  end
  // The sensor on pin A only wins while the unit leaves that pin as an input
  assign cap_o = oe_i[0] ? pin_i[0] : drive_a_i;
endmodule : ecmc_bridge_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import ecmc_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  ecmc_bus_s bus = '0;
  logic [15:0] tval = 16'h0000;
  logic drv_a = 1'b1;
  logic [3:0] latch = 4'h5;
  logic [3:0] dir = 4'h0;
  logic cap;
  logic tmr_rst;
  logic flag;
  logic [7:0] rdata;
  logic [3:0] pin;
  logic [3:0] oe;
  logic [3:0] pad;
  int n_fail = 0;
  int checks_done = 0;
  int n_trig = 0;

  always #4 mclk_i = ~mclk_i;

  // Pulses are counted so that a missing or doubled trigger both show
  always @(posedge mclk_i) begin
    if (tmr_rst === 1'b1) begin
      n_trig++;
    end
  end

  ecmc_top ecmc_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus), .ext_timer_i(tval),
    .cap_in_i(cap), .port_latch_i(latch), .port_dir_i(dir), .rdata_o(rdata), .pin_o(pin),
    .pin_oe_o(oe), .timer_reset_o(tmr_rst), .event_flag_o(flag));
  ecmc_bridge_model ecmc_bridge_model_i (.pin_i(pin), .oe_i(oe), .drive_a_i(drv_a),
    .pad_o(pad), .cap_o(cap));

  task automatic stop_test;
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge mclk_i);
    bus.wr <= 1'b0;
    @(posedge mclk_i);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge mclk_i);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge mclk_i);
  endtask : rd

  // Pads are judged through the bridge, so a wrong enable shows as well
  task automatic pins(input logic [3:0] m, input logic [3:0] e);
    tick(2);
    #1 chk({4'h0, pad & m}, {4'h0, e & m});
    chk({4'h0, oe}, {4'h0, ~dir});
    @(posedge mclk_i);
  endtask : pins

  task automatic chkf(input logic e);
    #1 chk({7'h00, flag}, {7'h00, e});
    @(posedge mclk_i);
  endtask : chkf

  task automatic pulse;
    drv_a <= 1'b0;
    tick(3);
    drv_a <= 1'b1;
    tick(3);
  endtask : pulse

  task automatic regs;
    rd(OFS_U1_CTRL, 8'h00);
    wr(OFS_U1_CTRL, 8'haa);
    rd(OFS_U1_CTRL, 8'haa);
    wr(OFS_U1_CTRL, 8'h55);
    rd(OFS_U1_CTRL, 8'h55);
    wr(OFS_U2_CTRL, 8'hff);
    rd(OFS_U2_CTRL, 8'h3f);
    wr(OFS_TCTRL, 8'hff);
    rd(OFS_TCTRL, 8'h7f);
    wr(OFS_SHDN, 8'hff);
    rd(OFS_SHDN, 8'hff);
    wr(OFS_DBCFG, 8'hff);
    rd(OFS_DBCFG, 8'hff);
    rd(4'hc, 8'h00);
  endtask : regs

  task automatic pwm;
    wr(OFS_U1_CTRL, 8'h00);
    wr(OFS_PERIOD, 8'h03);
    wr(OFS_U1_LO, 8'h01);
    dir <= 4'h0;
    wr(OFS_TCTRL, 8'h04);
    for (int p = 0; p < 4; p++) begin
      wr(OFS_U1_CTRL, 8'h7c | 8'(p));
      pins(4'h7, {1'b0, p[1], p[0], ~p[1]});
      wr(OFS_U1_CTRL, 8'hfc | 8'(p));
      pins(4'hd, {p[0], ~p[1], 1'b0, p[1]});
    end
    rd(OFS_U1_HI, 8'h01);
    wr(OFS_U1_HI, 8'h55);
    rd(OFS_U1_HI, 8'h01);
    wr(OFS_U1_CTRL, 8'h0c);
    pins(4'he, latch);
    wr(OFS_U1_CTRL, 8'h8c);
    pins(4'hc, latch);
    wr(OFS_U1_CTRL, 8'hca);
    pins(4'hf, latch);
  endtask : pwm

  task automatic cmp(input logic [7:0] md, input logic a0, input logic a1, input int tr);
    int t0;
    wr(OFS_U1_CTRL, md);
    wr(OFS_STATUS, 8'h01);
    pins(4'h1, {3'b000, a0});
    chk({7'h00, flag}, 8'h00);
    t0 = n_trig;
    tval <= 16'h1234;
    tick(1);
    tval <= 16'h0000;
    pins(4'h1, {3'b000, a1});
    chk({7'h00, flag}, 8'h01);
    chk(8'(n_trig - t0), 8'(tr));
  endtask : cmp

  task automatic compare;
    wr(OFS_U1_CTRL, 8'h00);
    wr(OFS_U1_LO, 8'h34);
    wr(OFS_U1_HI, 8'h12);
    cmp(8'h08, 1'b0, 1'b1, 0);
    cmp(8'h09, 1'b1, 1'b0, 0);
    wr(OFS_U1_CTRL, 8'h00);
    pins(4'h1, latch);
    cmp(8'h02, 1'b0, 1'b1, 0);
    cmp(8'h02, 1'b1, 1'b0, 0);
    cmp(8'h0a, 1'b1, 1'b1, 0);
    cmp(8'h0b, 1'b1, 1'b1, 1);
  endtask : compare

  task automatic cap_one(input logic [7:0] md, input int n);
    wr(OFS_U1_CTRL, 8'h00);
    wr(OFS_U1_CTRL, md);
    wr(OFS_STATUS, 8'h01);
    repeat (n - 1) pulse();
    chkf(1'b0);
    pulse();
    chkf(1'b1);
  endtask : cap_one

  task automatic capture;
    dir <= 4'h1;
    tval <= 16'habcd;
    cap_one(8'h03, 1);
    cap_one(8'h04, 1);
    cap_one(8'h06, 4);
    cap_one(8'h07, 16);
    cap_one(8'h05, 1);
    rd(OFS_U1_HI, 8'hab);
    rd(OFS_U1_LO, 8'hcd);
  endtask : capture

  initial begin
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    regs();
    pwm();
    compare();
    capture();
    stop_test();
  end

  // The whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    stop_test();
  end
endmodule : tb_top
